//--- hw/spm_pkg.sv
// package: register map, mode codes and timing constants of the power mode controller
package spm_pkg;
	// apb register byte offsets
	localparam logic [7:0] SPM_ADDR_MODE    = 8'h00;
	localparam logic [7:0] SPM_ADDR_SLEEP   = 8'h04;
	localparam logic [7:0] SPM_ADDR_PORTPD  = 8'h08;
	localparam logic [7:0] SPM_ADDR_EEE     = 8'h0c;
	localparam logic [7:0] SPM_ADDR_STATUS  = 8'h10;
	// field positions
	localparam int SPM_MODE_LSB     = 3;
	localparam int SPM_MODE_MSB     = 4;
	localparam int SPM_PORTPD_BIT   = 3;
	localparam int SPM_EEE_LOCAL    = 0;
	localparam int SPM_EEE_PARTNER  = 1;
	localparam int SPM_EEE_REQ      = 2;
	// power mode codes
	localparam logic [1:0] SPM_MODE_NORMAL = 2'h0;
	localparam logic [1:0] SPM_MODE_ENERGY = 2'h1;
	localparam logic [1:0] SPM_MODE_SOFTPD = 2'h2;
	localparam logic [1:0] SPM_MODE_RSVD   = 2'h3;
	localparam logic [7:0] SPM_SLEEP_RST   = 8'h00;
	// timing
	localparam int SPM_CLK_MHZ       = 250;
	localparam int SPM_PULSE_NS      = 120;
	localparam int SPM_PULSE_CYC     = (SPM_PULSE_NS * SPM_CLK_MHZ + 999) / 1000;
	localparam int SPM_PERIOD_S      = 1;
	localparam int SPM_LF_HZ         = 32768;
	localparam int SPM_PERIOD_LF     = SPM_PERIOD_S * SPM_LF_HZ;
	localparam int SPM_WAKE_DLY_CYC  = 16;
	typedef enum logic [1:0] {SPM_ST_RUN, SPM_ST_ED_NORM, SPM_ST_ED_LOW, SPM_ST_SOFTPD} spm_state_t;
endpackage

//--- hw/spm_top.sv
// power mode controller: global modes, energy-detect sleep, soft power-down wake, port power-down and eee lpi
// Functional notes
// [RULE1] mode field: 00 normal, 01 energy, 10 softpd
// [RULE2] mode field resets to normal
// [RULE3] host changes mode by writing field
// [RULE4] low-power state: only energy detect stays on
// [RULE5] emit 120 ns pulse once per second
// [RULE6] sleep after no energy beyond timeout
// [RULE7] energy in low power returns to normal
// [RULE8] packets pass only in normal power state
// [RULE9] softpd stops clocks, phys and macs
// [RULE10] any host access wakes from softpd
// [RULE11] wake issues internal register reset
// [RULE12] per-port control bit powers down port
// [RULE13] mii control power-down bit also powers down
// [RULE14] lpi directions independent
// [RULE15] gate mac and switch clocks during lpi; the code gates only the mac clock, and only while both directions are in lpi
// [RULE16] switch requests lpi toward phy
// [RULE17] partner lpi shown to switch
// [RULE18] mac defers via carrier sense in lpi
// [RULE19] lpi transitions keep link and frames
// [RULE20] lpi request blocks mac, release delays transmit
// [RULE21] partner assert-idle raises flag, cleared otherwise
// [RULE22] lpi only when both ends advertised
// [RULE23] timers count always-on low-frequency ticks
// [RULE24] reserved mode write is ignored
`timescale 1ns/1ps
module spm_top
	import spm_pkg::*;
#(
	parameter int NPORTS   = 3,
	parameter int PERIOD_LF = SPM_PERIOD_LF
)(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              lf_tick,
	input  wire logic              energy_in,
	input  wire logic [NPORTS-1:0] mii_pd_bit,
	input  wire logic              switch_lpi_req,
	input  wire logic              rx_assert_lpi,
	output logic                   pll_clk_en,
	output logic                   mac_en,
	output logic                   host_if_en,
	output logic                   phy_en,
	output logic                   phy_rx_ed_only,
	output logic                   pkt_en,
	output logic                   line_pulse,
	output logic                   soft_rst,
	output logic [NPORTS-1:0]      port_pd,
	output logic                   tx_assert_lpi,
	output logic                   mac_tx_allow,
	output logic                   mac_crs_defer,
	output logic                   mac_clk_gate,
	output logic                   partner_idle_flag
);
	import spm_pkg::*;

	typedef struct packed {
		logic [1:0]        mode;
		logic [7:0]        sleep_to;
		logic [NPORTS-1:0] pd;
		logic              eee_local;
		logic              eee_partner;
		logic              lpi_req;
		spm_state_t        st;
		logic [7:0]        idle_ticks;
		logic [31:0]       lf_cnt;
		logic [7:0]        pulse_cnt;
		logic [7:0]        wake_cnt;
		logic              tx_lpi;
		logic              tx_allow;
		logic              pidle;
		logic              srst;
		logic              tick_d;
		logic [1:0]        tick_s;
		logic [1:0]        energy_s;
		logic [1:0]        rxlpi_s;
		logic [31:0]       rdata;
	} spm_regs_t;

	spm_regs_t s_reg;
	spm_regs_t s_next;

	logic acc;
	logic wr;
	logic tick_rise;
	logic eee_ok;

	assign acc       = psel && penable;
	assign wr        = acc && pwrite;
	assign tick_rise = s_reg.tick_s[1] && !s_reg.tick_d;
	assign eee_ok    = s_reg.eee_local && s_reg.eee_partner;

	always_comb
	begin
		s_next = s_reg;
		s_next.srst = 1'b0;
		// slow tick, cable energy and partner idle come from other domains: two flops each
		s_next.tick_s   = {s_reg.tick_s[0], lf_tick};
		s_next.tick_d   = s_reg.tick_s[1];
		s_next.energy_s = {s_reg.energy_s[0], energy_in};
		s_next.rxlpi_s  = {s_reg.rxlpi_s[0], rx_assert_lpi};

		// register writes; none in soft power-down, where the setup phase of an access wakes the block
		if (wr && s_reg.st != SPM_ST_SOFTPD)
		begin
			unique case (paddr)
				SPM_ADDR_MODE:
				begin
					if (pwdata[SPM_MODE_MSB:SPM_MODE_LSB] != SPM_MODE_RSVD) // [RULE24]
						s_next.mode = pwdata[SPM_MODE_MSB:SPM_MODE_LSB]; // [RULE3]
				end
				SPM_ADDR_SLEEP:
				begin
					s_next.sleep_to = pwdata[7:0];
				end
				SPM_ADDR_PORTPD:
				begin
					s_next.pd = pwdata[SPM_PORTPD_BIT +: NPORTS]; // [RULE12]
				end
				SPM_ADDR_EEE:
				begin
					s_next.eee_local   = pwdata[SPM_EEE_LOCAL];
					s_next.eee_partner = pwdata[SPM_EEE_PARTNER];
				end
				default: ;
			endcase
		end

		// read word is latched in the setup cycle so it stands through the access phase
		s_next.rdata = 32'h0;
		unique case (paddr)
			SPM_ADDR_MODE:
			begin
				s_next.rdata[SPM_MODE_MSB:SPM_MODE_LSB] = s_reg.mode;
			end
			SPM_ADDR_SLEEP:
			begin
				s_next.rdata[7:0] = s_reg.sleep_to;
			end
			SPM_ADDR_PORTPD:
			begin
				s_next.rdata[SPM_PORTPD_BIT +: NPORTS] = s_reg.pd;
			end
			SPM_ADDR_EEE:
			begin
				s_next.rdata[SPM_EEE_LOCAL]   = s_reg.eee_local;
				s_next.rdata[SPM_EEE_PARTNER] = s_reg.eee_partner;
				s_next.rdata[SPM_EEE_REQ]     = s_reg.tx_lpi;
			end
			SPM_ADDR_STATUS:
			begin
				s_next.rdata[1:0] = s_reg.st;
				s_next.rdata[2]   = s_reg.pidle;
				s_next.rdata[3]   = s_reg.tx_allow;
			end
			default: ;
		endcase

		// always-on low-frequency timers; they keep counting while pll clocks are stopped
		if (tick_rise) // [RULE23]
		begin
			s_next.lf_cnt = (s_reg.lf_cnt >= 32'(PERIOD_LF - 1)) ? 32'h0 : s_reg.lf_cnt + 32'h1;
		end
		// one line pulse per period, started only in the low-power state
		if (s_reg.st == SPM_ST_ED_LOW && tick_rise && s_reg.lf_cnt == 32'h0)
		begin
			s_next.pulse_cnt = 8'(SPM_PULSE_CYC); // [RULE5]
		end
		else if (s_reg.pulse_cnt != 8'h0)
		begin
			s_next.pulse_cnt = s_reg.pulse_cnt - 8'h1;
		end

		// power state machine
		unique case (s_reg.st)
			SPM_ST_RUN:
			begin
				if (s_reg.mode == SPM_MODE_ENERGY) // [RULE1]
				begin
					s_next.st = SPM_ST_ED_NORM;
					s_next.idle_ticks = 8'h0;
				end
				else if (s_reg.mode == SPM_MODE_SOFTPD)
				begin
					s_next.st = SPM_ST_SOFTPD; // [RULE9]
				end
			end
			SPM_ST_ED_NORM:
			begin
				// a mode change away from energy detect only acts in the normal power state
				if (s_reg.mode != SPM_MODE_ENERGY)
				begin
					s_next.st = SPM_ST_RUN;
				end
				else if (s_reg.energy_s[1])
				begin
					s_next.idle_ticks = 8'h0;
				end
				else if (tick_rise)
				begin
					if (s_reg.idle_ticks >= s_reg.sleep_to)
					begin
						s_next.st = SPM_ST_ED_LOW; // [RULE6]
					end
					else
					begin
						s_next.idle_ticks = s_reg.idle_ticks + 8'h1;
					end
				end
			end
			SPM_ST_ED_LOW:
			begin
				if (s_reg.energy_s[1]) // [RULE7]
				begin
					s_next.st = SPM_ST_ED_NORM;
					s_next.idle_ticks = 8'h0;
				end
			end
			SPM_ST_SOFTPD:
			begin
				// a waking write still lands after the reset; a waking read returns zero
				if (psel) // [RULE10]
				begin
					s_next = '0;
					s_next.st = SPM_ST_RUN;
					s_next.srst = 1'b1; // [RULE11]
				end
			end
		endcase

		// eee low-power idle, transmit side
		// release keeps transmit off for a fixed wake delay so the partner can resume
		s_next.lpi_req = switch_lpi_req && eee_ok; // [RULE22]
		if (s_reg.lpi_req && s_reg.st != SPM_ST_SOFTPD)
		begin
			s_next.tx_lpi   = 1'b1; // [RULE16]
			s_next.tx_allow = 1'b0; // [RULE20]
			s_next.wake_cnt = 8'(SPM_WAKE_DLY_CYC);
		end
		else
		begin
			s_next.tx_lpi = 1'b0;
			if (s_reg.wake_cnt != 8'h0)
			begin
				s_next.wake_cnt = s_reg.wake_cnt - 8'h1;
			end
			s_next.tx_allow = (s_reg.wake_cnt <= 8'h1); // [RULE19]
		end

		// receive side, independent of transmit
		s_next.pidle = s_reg.rxlpi_s[1] && eee_ok; // [RULE14] [RULE21]
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_reg.mode        <= SPM_MODE_NORMAL; // [RULE2]
			s_reg.sleep_to    <= SPM_SLEEP_RST;
			s_reg.pd          <= '0;
			s_reg.eee_local   <= 1'b0;
			s_reg.eee_partner <= 1'b0;
			s_reg.lpi_req     <= 1'b0;
			s_reg.st          <= SPM_ST_RUN;
			s_reg.idle_ticks  <= '0;
			s_reg.lf_cnt      <= '0;
			s_reg.pulse_cnt   <= '0;
			s_reg.wake_cnt    <= '0;
			s_reg.tx_lpi      <= 1'b0;
			// no idle pending out of reset, so the mac may transmit at once
			s_reg.tx_allow    <= 1'b1;
			s_reg.pidle       <= 1'b0;
			s_reg.srst        <= 1'b0;
			s_reg.tick_d      <= 1'b0;
			s_reg.tick_s      <= '0;
			s_reg.energy_s    <= '0;
			s_reg.rxlpi_s     <= '0;
			s_reg.rdata       <= '0;
		end
		else
			s_reg <= s_next;
	end

	// apb: zero wait state; unmapped reads return zero
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign prdata  = s_reg.rdata;

	// block enables per power state
	always_comb
	begin
		pll_clk_en     = 1'b0;
		mac_en         = 1'b0;
		host_if_en     = 1'b0;
		phy_en         = 1'b0;
		phy_rx_ed_only = 1'b0;
		pkt_en         = 1'b0;
		unique case (s_reg.st)
			SPM_ST_RUN:
			begin
				pll_clk_en = 1'b1;
				mac_en     = 1'b1;
				host_if_en = 1'b1;
				phy_en     = 1'b1;
				pkt_en     = 1'b1;
			end
			SPM_ST_ED_NORM:
			begin
				pll_clk_en = 1'b1;
				mac_en     = 1'b1;
				host_if_en = 1'b1;
				phy_en     = 1'b1;
				pkt_en     = 1'b1; // [RULE8]
			end
			SPM_ST_ED_LOW:
			begin
				phy_rx_ed_only = 1'b1; // [RULE4]
			end
			SPM_ST_SOFTPD:
			begin
				phy_rx_ed_only = 1'b0; // [RULE9]
			end
		endcase
	end

	assign line_pulse        = (s_reg.pulse_cnt != 8'h0);
	assign soft_rst          = s_reg.srst;
	// per-port power-down: either control source turns the port off
	for (genvar p = 0; p < NPORTS; p++)
	begin : g_port_pd
		assign port_pd[p] = s_reg.pd[p] || mii_pd_bit[p]; // [RULE13]
	end
	assign tx_assert_lpi     = s_reg.tx_lpi;
	assign mac_tx_allow      = s_reg.tx_allow;
	assign mac_crs_defer     = s_reg.tx_lpi || !s_reg.tx_allow; // [RULE18]
	assign mac_clk_gate      = s_reg.tx_lpi && s_reg.pidle; // [RULE15]
	assign partner_idle_flag = s_reg.pidle; // [RULE17]
endmodule

//--- tb/spm_chk.sv
// checker: power mode controller port assertions
`timescale 1ns/1ps
module spm_chk #(
	parameter int NPORTS = 3
)(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              pll_clk_en,
	input wire logic              mac_en,
	input wire logic              host_if_en,
	input wire logic              phy_en,
	input wire logic              phy_rx_ed_only,
	input wire logic              pkt_en,
	input wire logic              line_pulse,
	input wire logic              soft_rst,
	input wire logic [NPORTS-1:0] mii_pd_bit,
	input wire logic [NPORTS-1:0] port_pd,
	input wire logic              switch_lpi_req,
	input wire logic              tx_assert_lpi,
	input wire logic              mac_tx_allow,
	input wire logic              rx_assert_lpi,
	input wire logic              partner_idle_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	ed_low_off_a: assert property (phy_rx_ed_only |-> !pll_clk_en && !mac_en && !host_if_en)
		else $error("low power state leaves blocks on");
	clk_off_a: assert property (!pll_clk_en |-> !mac_en && !phy_en && !pkt_en)
		else $error("blocks on without pll clocks");
	pkt_gate_a: assert property (pkt_en |-> pll_clk_en && !phy_rx_ed_only)
		else $error("packets outside normal power state");
	line_pulse_a: assert property ($rose(line_pulse) |-> phy_rx_ed_only && line_pulse [*8])
		else $error("line pulse outside low state or too short");
	wake_rst_a: assert property (soft_rst |=> !soft_rst ##[0:3] pll_clk_en)
		else $error("wake reset not one pulse into normal mode");
	lpi_req_a: assert property (tx_assert_lpi |-> $past(switch_lpi_req, 2))
		else $error("idle assert without request");
	lpi_block_a: assert property (tx_assert_lpi |-> !mac_tx_allow)
		else $error("mac allowed during idle assert");
	partner_flag_a: assert property (partner_idle_flag |-> $past(rx_assert_lpi, 3))
		else $error("partner idle flag without idle encoding");
	mii_pd_a: assert property ((port_pd & mii_pd_bit) == mii_pd_bit)
		else $error("management power-down bit ignored");
endmodule
bind spm_top spm_chk #(.NPORTS(NPORTS)) chk_i (.*);

//--- tb/spm_link_model.sv
// link side model: always-on slow tick, cable energy and partner lpi
`timescale 1ns/1ps
module spm_link_model(
	input  wire logic cable_on,
	input  wire logic partner_lpi,
	output logic      lf_tick,
	output logic      energy_in,
	output logic      rx_assert_lpi
);
	initial lf_tick = 1'b0;
	// free running, also while pll clocks are stopped
	always #32 lf_tick = ~lf_tick;
	assign energy_in = cable_on;
	assign rx_assert_lpi = partner_lpi;
endmodule

//--- tb/switch_power_mode_control_tb.sv
// testbench: apb driven power mode scenarios
`timescale 1ns/1ps
module switch_power_mode_control_tb;
	import spm_pkg::*;
	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, lf_tick, energy_in;
	logic        switch_lpi_req, rx_assert_lpi, pll_clk_en, mac_en, host_if_en, phy_en;
	logic        phy_rx_ed_only, pkt_en, line_pulse, soft_rst, tx_assert_lpi, mac_tx_allow;
	logic        mac_crs_defer, mac_clk_gate, partner_idle_flag, cable, plpi;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [2:0]  mii_pd_bit, port_pd;
	int          n_errors, checks, n;
	spm_top #(.PERIOD_LF(8)) dut (.*);
	spm_link_model lm (.cable_on(cable), .partner_lpi(plpi), .lf_tick, .energy_in, .rx_assert_lpi);
	initial clk = 1'b0;
	always #2 clk = ~clk;
	task tally_and_finish();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function automatic logic sel(input int k);
		case (k)
			0: return phy_rx_ed_only;
			1: return pkt_en;
			2: return line_pulse;
			3: return tx_assert_lpi;
			4: return partner_idle_flag;
			5: return mac_tx_allow;
			default: return pll_clk_en;
		endcase
	endfunction
	task waitv(input int k, input logic v);
		int c;
		c = 0;
		while (sel(k) !== v && c < 3000)
		begin
			@(negedge clk);
			c++;
		end
		if (c >= 3000)
		begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		logic ok;
		int   c;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		c = 0;
		do
		begin
			@(posedge clk);
			ok = pready;
			q = prdata;
			c++;
		end
		while (ok !== 1'b1 && c < 100);
		psel <= 1'b0;
		penable <= 1'b0;
		if (ok !== 1'b1)
		begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, switch_lpi_req, plpi, mii_pd_bit} = '0;
		{sys_rst, cable, n_errors, checks} = {2'b11, 64'h0};
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(SPM_ADDR_MODE, 32'h0);
		apb(1'b1, SPM_ADDR_MODE, 32'h18, r);
		rd(SPM_ADDR_MODE, 32'h0);
		apb(1'b1, SPM_ADDR_SLEEP, 32'h2, r);
		apb(1'b1, SPM_ADDR_MODE, 32'h8, r);
		rd(SPM_ADDR_MODE, 32'h8);
		waitv(1, 1'b1);
		@(posedge clk) cable <= 1'b0;
		waitv(0, 1'b1);
		chk(32'(pll_clk_en), 32'h0);
		waitv(2, 1'b1);
		n = 0;
		while (line_pulse === 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		chk(32'(n), 32'(SPM_PULSE_CYC));
		@(posedge clk) cable <= 1'b1;
		waitv(1, 1'b1);
		apb(1'b1, SPM_ADDR_MODE, 32'h0, r);
		apb(1'b1, SPM_ADDR_EEE, 32'h3, r);
		@(posedge clk) switch_lpi_req <= 1'b1;
		waitv(3, 1'b1);
		chk(32'(mac_tx_allow), 32'h0);
		@(posedge clk) plpi <= 1'b1;
		waitv(4, 1'b1);
		chk(32'(mac_crs_defer), 32'h1);
		@(posedge clk) switch_lpi_req <= 1'b0;
		waitv(3, 1'b0);
		chk({mac_tx_allow, partner_idle_flag}, 32'h1);
		waitv(5, 1'b1);
		@(posedge clk) plpi <= 1'b0;
		waitv(4, 1'b0);
		apb(1'b1, SPM_ADDR_EEE, 32'h1, r);
		@(posedge clk) switch_lpi_req <= 1'b1;
		repeat (10) @(negedge clk);
		chk(32'(tx_assert_lpi), 32'h0);
		@(posedge clk) switch_lpi_req <= 1'b0;
		apb(1'b1, SPM_ADDR_PORTPD, 32'h8, r);
		@(posedge clk) mii_pd_bit <= 3'h2;
		@(negedge clk);
		chk(32'(port_pd), 32'h3);
		apb(1'b1, SPM_ADDR_SLEEP, 32'h5, r);
		apb(1'b1, SPM_ADDR_MODE, 32'h10, r);
		waitv(6, 1'b0);
		chk({phy_en, mac_en}, 32'h0);
		apb(1'b0, SPM_ADDR_STATUS, 32'h0, r);
		waitv(6, 1'b1);
		rd(SPM_ADDR_SLEEP, 32'h0);
		rd(SPM_ADDR_MODE, 32'h0);
		chk(32'(port_pd), 32'h2);
		tally_and_finish();
	end
endmodule
